// ==== common/psw_pkg.sv ====
// package for the power-save and wake-up controller
package psw_pkg;

	// register byte addresses (printed offsets are multiples of four)
	localparam logic [11:0] PSW_WAKEUP_CONTROL_REG_ADDR = 12'h768;
	localparam logic [11:0] PSW_IRQ_FLAG_STATUS_5_ADDR  = 12'h76C;
	localparam logic [11:0] PSW_IRQ_MASK_ADDR           = 12'h770;
	localparam logic [11:0] PSW_POWER_CTRL_ADDR         = 12'h774;
	localparam logic [11:0] PSW_POWER_STATUS_ADDR       = 12'h778;

	// wake-up control register fields and reset value
	localparam int          PSW_WAKEUP_ENABLE_BIT       = 15;
	localparam int          PSW_WAKEUP_STOP_IN_IDLE_BIT = 13;
	localparam int          PSW_DISCHARGE_SINK_BIT      = 8;
	localparam logic [15:0] PSW_WAKEUP_CONTROL_RESET    = 16'h0000;

	// status and mask layout: event bits
	localparam int          PSW_WAKEUP_IRQ_FLAG_BIT     = 0;
	localparam int          PSW_IDLE_WAKE_BIT           = 1;
	localparam int          PSW_SLEEP_WAKE_BIT          = 2;
	localparam int          PSW_EVENT_COUNT             = 3;
	localparam logic [2:0]  PSW_STATUS_RESET            = 3'h0;
	localparam logic [2:0]  PSW_MASK_RESET              = 3'h0;

	// power control fields: watchdog and clock monitor enables
	localparam int          PSW_WATCHDOG_EN_BIT         = 0;
	localparam int          PSW_FAIL_SAFE_EN_BIT        = 1;
	localparam logic [1:0]  PSW_POWER_CTRL_RESET        = 2'h0;

	// power-save instruction operand codes
	localparam logic        PSW_MODE_SLEEP              = 1'b0;
	localparam logic        PSW_MODE_IDLE               = 1'b1;

	// power states of the core
	typedef enum logic [1:0] {
		PSW_RUN   = 2'b00,
		PSW_ENTER = 2'b01,
		PSW_IDLE  = 2'b10,
		PSW_SLEEP = 2'b11
	} psw_state_type;

	// request from the core's instruction decoder
	typedef struct packed {
		logic valid;
		logic mode;
	} psw_save_req_type;

	// wake causes collected from the rest of the chip
	typedef struct packed {
		logic irq_pending;
		logic device_reset;
		logic watchdog_timeout;
	} psw_wake_src_type;

endpackage : psw_pkg

// ==== rtl/psw_sync.sv ====
// two flip-flop synchroniser for the wake-up pin input
`timescale 1ns/1ps
module psw_sync
	import psw_pkg::*;
(
	input  wire logic clk_in,     // system clock
	input  wire logic sys_rst_in, // synchronous reset, active high
	input  wire logic async_in,   // level from outside the clock domain
	output logic      sync_out    // synchronised level
);
	logic stage1;
	logic next_stage1;
	logic next_sync;

	// first stage is read only by the second
	always_comb
	begin
		next_stage1 = async_in;
		next_sync   = stage1;
	end

	// pin idles high when the capacitor is charged, so reset to one
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			stage1   <= 1'b1;
			sync_out <= 1'b1;
		end
		else
		begin
			stage1   <= next_stage1;
			sync_out <= next_sync;
		end
	end
endmodule : psw_sync

// ==== rtl/psw_apb.sv ====
// apb slave front end: decodes a one-cycle write strobe and registers read data
`timescale 1ns/1ps
module psw_apb
	import psw_pkg::*;
(
	input  wire logic        clk_in,     // system clock
	input  wire logic        sys_rst_in, // synchronous reset, active high
	input  wire logic        psel,       // apb select
	input  wire logic        penable,    // apb access phase
	input  wire logic        pwrite,     // apb direction
	input  wire logic [11:0] paddr,      // apb byte address
	input  wire logic [31:0] rdata_in,   // read word from register file
	output logic             pready,     // apb ready, one wait state
	output logic [31:0]      prdata,     // apb read data
	output logic             pslverr,    // apb error for unmapped address
	output logic             wr_stb_out, // write strobe, one cycle
	input  wire logic        hit_in      // address maps to a register
);
	logic        next_pready;
	logic [31:0] next_prdata;
	logic        next_pslverr;
	logic        next_wr_stb;

	// answer on the second access cycle so read data come from a flop
	always_comb
	begin
		next_pready  = psel && penable && !pready;
		next_prdata  = prdata;
		next_pslverr = 1'b0;
		next_wr_stb  = 1'b0;
		if (next_pready)
		begin
			next_prdata  = (!pwrite && hit_in) ? rdata_in : 32'h0000_0000;
			next_pslverr = !hit_in;
			next_wr_stb  = pwrite && hit_in;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			pready     <= 1'b0;
			prdata     <= 32'h0000_0000;
			pslverr    <= 1'b0;
			wr_stb_out <= 1'b0;
		end
		else
		begin
			pready     <= next_pready;
			prdata     <= next_prdata;
			pslverr    <= next_pslverr;
			wr_stb_out <= next_wr_stb;
		end
	end
endmodule : psw_apb

// ==== rtl/psw_top.sv ====
// power-save, idle and ultra low-power wake-up controller
// How it works
// - in idle the core is halted until a wake event arrives
// - entering idle pulses the watchdog clear
// - system clock stays on in idle; peripherals run unless disabled
// - rc oscillator stays on in idle when watchdog or monitor enabled
// - idle ends on enabled interrupt, device reset or watchdog time-out
// - on wake the core clock returns and execution resumes at once
// - interrupt during power-save instruction is held until entry completes
// - a true power-on reset resets all logic
// - enable and sink bits both set turn on the discharge sink
// - wake-up pin below low threshold in sleep wakes the device
// - ultra low-power wake from sleep sets the wake-up interrupt flag
// - wake-up control register at 768h, reset 0000, bits 15, 13, 8
`timescale 1ns/1ps
module psw_top
	import psw_pkg::*;
(
	input  wire logic             clk_in,          // system clock 250 MHz
	input  wire logic             sys_rst_in,      // sync reset, active high
	input  wire logic             por_in,          // power-on reset from supply
	input  wire logic             psel,            // apb select
	input  wire logic             penable,         // apb enable
	input  wire logic             pwrite,          // apb write
	input  wire logic [11:0]      paddr,           // apb address
	input  wire logic [31:0]      pwdata,          // apb write data
	output logic                  pready,          // apb ready
	output logic [31:0]           prdata,          // apb read data
	output logic                  pslverr,         // apb error
	input  wire psw_save_req_type save_req_in,     // power-save instruction
	input  wire psw_wake_src_type wake_src_in,     // wake causes
	input  wire logic [7:0]       periph_dis_in,   // per-module disable bits
	input  wire logic             wakeup_pin_in,   // wake-up pin input level
	output logic                  cpu_clk_en_out,  // core clock gate enable
	output logic                  sys_clk_en_out,  // system clock source on
	output logic [7:0]            periph_clk_out,  // per-module clock enable
	output logic                  low_power_rc_osc_en_out,     // rc oscillator enable
	output logic                  wdt_clear_out,   // watchdog clear pulse
	output logic                  wake_pulse_out,  // core resumes, one cycle
	output logic                  sink_en_out,     // discharge sink on
	output logic                  irq_out          // level interrupt
);
	////////////////////////////////////////////////////////////////////////
	// power-on reset joins the system reset so every flop resets
	logic rst;
	assign rst = sys_rst_in || por_in;

	////////////////////////////////////////////////////////////////////////
	// pin synchroniser and bus front end
	logic        pin_sync;
	logic        wr_stb;
	logic        hit;
	logic [31:0] rdata;

	psw_sync u_sync (
		.clk_in     (clk_in),
		.sys_rst_in (rst),
		.async_in   (wakeup_pin_in),
		.sync_out   (pin_sync)
	);

	psw_apb u_apb (
		.clk_in     (clk_in),
		.sys_rst_in (rst),
		.psel       (psel),
		.penable    (penable),
		.pwrite     (pwrite),
		.paddr      (paddr),
		.rdata_in   (rdata),
		.pready     (pready),
		.prdata     (prdata),
		.pslverr    (pslverr),
		.wr_stb_out (wr_stb),
		.hit_in     (hit)
	);

	////////////////////////////////////////////////////////////////////////
	// registers
	logic                       wake_en;
	logic                       stop_in_idle;
	logic                       sink_bit;
	logic [PSW_EVENT_COUNT-1:0] status;
	logic [PSW_EVENT_COUNT-1:0] mask;
	logic [1:0]                 power_ctrl;
	psw_state_type              state;
	logic                       held_irq;

	// address decode and read mux
	always_comb
	begin
		hit   = 1'b1;
		rdata = 32'h0000_0000;
		case (paddr)
			PSW_WAKEUP_CONTROL_REG_ADDR:
			begin
				rdata[PSW_WAKEUP_ENABLE_BIT]       = wake_en;
				rdata[PSW_WAKEUP_STOP_IN_IDLE_BIT] = stop_in_idle;
				rdata[PSW_DISCHARGE_SINK_BIT]      = sink_bit;
			end
			PSW_IRQ_FLAG_STATUS_5_ADDR: rdata[2:0] = status;
			PSW_IRQ_MASK_ADDR:          rdata[2:0] = mask;
			PSW_POWER_CTRL_ADDR:        rdata[1:0] = power_ctrl;
			PSW_POWER_STATUS_ADDR:      rdata[1:0] = state;
			default:                    hit = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// power state machine
	psw_state_type next_state;
	logic          next_held_irq;
	logic          next_wdt_clear;
	logic          next_wake_pulse;
	logic [PSW_EVENT_COUNT-1:0] wake_evt;
	logic          idle_wake;
	logic          pin_low_wake;
	assign idle_wake = wake_src_in.irq_pending || wake_src_in.device_reset
		|| wake_src_in.watchdog_timeout;
	// pin below threshold only counts while armed and asleep
	assign pin_low_wake = wake_en && !pin_sync;
	always_comb
	begin
		next_state      = state;
		next_held_irq   = held_irq;
		next_wdt_clear  = 1'b0;
		next_wake_pulse = 1'b0;
		wake_evt        = '0;
		case (state)
			PSW_RUN:
			begin
				next_held_irq = 1'b0;
				if (save_req_in.valid)
				begin
					// an interrupt here is latched, not served
					next_held_irq = wake_src_in.irq_pending;
					next_state    = PSW_ENTER;
				end
			end
			PSW_ENTER:
			begin
				next_held_irq = held_irq || wake_src_in.irq_pending;
				if (save_req_in.mode == PSW_MODE_IDLE)
				begin
					next_state     = PSW_IDLE;
					next_wdt_clear = 1'b1;
				end
				else
					next_state = PSW_SLEEP;
			end
			PSW_IDLE:
			begin
				if (idle_wake || held_irq)
				begin
					next_state              = PSW_RUN;
					next_wake_pulse         = 1'b1;
					next_held_irq           = 1'b0;
					wake_evt[PSW_IDLE_WAKE_BIT] = 1'b1;
				end
			end
			PSW_SLEEP:
			begin
				if (idle_wake || held_irq || pin_low_wake)
				begin
					next_state      = PSW_RUN;
					next_wake_pulse = 1'b1;
					next_held_irq   = 1'b0;
					wake_evt[PSW_SLEEP_WAKE_BIT] = 1'b1;
					wake_evt[PSW_WAKEUP_IRQ_FLAG_BIT] = pin_low_wake;
				end
			end
			default: next_state = PSW_RUN;
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (rst)
		begin
			state          <= PSW_RUN;
			held_irq       <= 1'b0;
			wdt_clear_out  <= 1'b0;
			wake_pulse_out <= 1'b0;
		end
		else
		begin
			state          <= next_state;
			held_irq       <= next_held_irq;
			wdt_clear_out  <= next_wdt_clear;
			wake_pulse_out <= next_wake_pulse;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// software registers and sticky status
	logic                       next_wake_en;
	logic                       next_stop_in_idle;
	logic                       next_sink_bit;
	logic [PSW_EVENT_COUNT-1:0] next_status;
	logic [PSW_EVENT_COUNT-1:0] next_mask;
	logic [1:0]                 next_power_ctrl;
	always_comb
	begin
		next_wake_en      = wake_en;
		next_stop_in_idle = stop_in_idle;
		next_sink_bit     = sink_bit;
		next_mask         = mask;
		next_power_ctrl   = power_ctrl;
		next_status       = status;
		if (wr_stb)
		begin
			case (paddr)
				PSW_WAKEUP_CONTROL_REG_ADDR:
				begin
					next_wake_en      = pwdata[PSW_WAKEUP_ENABLE_BIT];
					next_stop_in_idle = pwdata[PSW_WAKEUP_STOP_IN_IDLE_BIT];
					next_sink_bit     = pwdata[PSW_DISCHARGE_SINK_BIT];
				end
				PSW_IRQ_FLAG_STATUS_5_ADDR:
					next_status = status & ~pwdata[2:0];
				PSW_IRQ_MASK_ADDR:   next_mask       = pwdata[2:0];
				PSW_POWER_CTRL_ADDR: next_power_ctrl = pwdata[1:0];
				default:             next_mask       = mask;
			endcase
		end
		// set after clear so a same-cycle event is never lost
		next_status = next_status | wake_evt;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst)
		begin
			wake_en      <= PSW_WAKEUP_CONTROL_RESET[PSW_WAKEUP_ENABLE_BIT];
			stop_in_idle <=
				PSW_WAKEUP_CONTROL_RESET[PSW_WAKEUP_STOP_IN_IDLE_BIT];
			sink_bit     <= PSW_WAKEUP_CONTROL_RESET[PSW_DISCHARGE_SINK_BIT];
			status       <= PSW_STATUS_RESET;
			mask         <= PSW_MASK_RESET;
			power_ctrl   <= PSW_POWER_CTRL_RESET;
		end
		else
		begin
			wake_en      <= next_wake_en;
			stop_in_idle <= next_stop_in_idle;
			sink_bit     <= next_sink_bit;
			status       <= next_status;
			mask         <= next_mask;
			power_ctrl   <= next_power_ctrl;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// clock enables, sink and interrupt, all from flops
	logic       next_cpu_clk;
	logic       next_low_power_rc_osc;
	logic       next_sink;
	logic       next_irq;
	logic [7:0] next_periph;
	logic       low_power;
	assign low_power = (next_state == PSW_IDLE) || (next_state == PSW_SLEEP);
	always_comb
	begin
		next_cpu_clk = !low_power;
		// sink discharges the pin capacitor; software charged it first
		next_sink = next_wake_en && next_sink_bit;
		next_low_power_rc_osc = (next_state != PSW_SLEEP) ||
			(|next_power_ctrl);
		next_irq = |(next_status & next_mask);
		// sleep stops the peripherals; idle keeps them on unless disabled
		next_periph = (next_state == PSW_SLEEP) ? 8'h00 : ~periph_dis_in;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst)
		begin
			cpu_clk_en_out <= 1'b1;
			sys_clk_en_out <= 1'b1;
			periph_clk_out <= 8'hFF;
			low_power_rc_osc_en_out    <= 1'b1;
			sink_en_out    <= 1'b0;
			irq_out        <= 1'b0;
		end
		else
		begin
			cpu_clk_en_out <= next_cpu_clk;
			sys_clk_en_out <= (next_state != PSW_SLEEP);
			periph_clk_out <= next_periph;
			low_power_rc_osc_en_out    <= next_low_power_rc_osc;
			sink_en_out    <= next_sink;
			irq_out        <= next_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions
	sequence idle_entry_s;
		state == PSW_ENTER && save_req_in.mode == PSW_MODE_IDLE;
	endsequence
	idle_halt_a: assert property (@(posedge clk_in) disable iff (rst)
		state == PSW_IDLE |-> !cpu_clk_en_out)
		else $error("core clock running in idle");
	wdt_clear_a: assert property (@(posedge clk_in) disable iff (rst)
		idle_entry_s |=> wdt_clear_out && state == PSW_IDLE)
		else $error("watchdog not cleared on idle entry");
	idle_sysclk_a: assert property (@(posedge clk_in) disable iff (rst)
		state == PSW_IDLE |-> sys_clk_en_out)
		else $error("system clock stopped in idle");
	low_power_rc_osc_keep_a: assert property (@(posedge clk_in) disable iff (rst)
		state == PSW_IDLE && $past(state) == PSW_IDLE && |power_ctrl
		|-> low_power_rc_osc_en_out)
		else $error("rc oscillator off in idle");
	idle_wake_a: assert property (@(posedge clk_in) disable iff (rst)
		state == PSW_IDLE && wake_src_in.watchdog_timeout
		|=> state == PSW_RUN && wake_pulse_out ##1 cpu_clk_en_out)
		else $error("idle did not end on time-out");
	held_irq_a: assert property (@(posedge clk_in) disable iff (rst)
		state == PSW_RUN && save_req_in.valid && wake_src_in.irq_pending
		|=> state == PSW_ENTER ##1 state != PSW_RUN ##1 state == PSW_RUN)
		else $error("coincident interrupt not held then woken");
	// checked from the bus write, not from the flops that feed the pin
	sink_on_a: assert property (@(posedge clk_in) disable iff (rst)
		wr_stb && paddr == PSW_WAKEUP_CONTROL_REG_ADDR
		|=> sink_en_out == ($past(pwdata[PSW_WAKEUP_ENABLE_BIT])
		&& $past(pwdata[PSW_DISCHARGE_SINK_BIT])))
		else $error("sink does not follow enable and sink bits");
	pin_wake_a: assert property (@(posedge clk_in) disable iff (rst)
		state == PSW_SLEEP && wake_en && !pin_sync
		|=> state == PSW_RUN && status[PSW_WAKEUP_IRQ_FLAG_BIT])
		else $error("pin low did not wake and flag");
	// a one-cycle reset clears the flag legally, so skip that edge
	flag_sticky_a: assert property (@(posedge clk_in) disable iff (rst)
		!$past(rst) && $past(status[PSW_WAKEUP_IRQ_FLAG_BIT])
		&& !$past(wr_stb) |-> status[PSW_WAKEUP_IRQ_FLAG_BIT])
		else $error("wake flag dropped without a write");
endmodule : psw_top

// ==== sim/psw_rc_model.sv ====
// rc network on the wake-up pin: charged by software, drained by the sink
`timescale 1ns/1ps
module psw_rc_model
(
	input  wire logic clk_in,    // system clock
	input  wire logic charge_in, // pin driven high as an output
	input  wire logic sink_in,   // discharge sink on
	output logic      pin_out    // level seen at the pin
);
	logic [5:0] level = 6'h00; // capacitor voltage in steps

	////////////////////////////////////////////////////////////////////////
	// charge at once, drain one step a cycle; no leak, so a hold is ideal
	always @(posedge clk_in)
	begin
		if (charge_in)
			level <= 6'h3F;
		else if (sink_in && level != 6'h00)
			level <= level - 6'h01;
	end

	// below the input-low threshold the pin reads low
	assign pin_out = (level > 6'h08);
endmodule : psw_rc_model

// ==== sim/psw_tb_top.sv ====
// self-checking bench for the power-save and wake-up controller
`timescale 1ns/1ps
module psw_tb_top
	import psw_pkg::*;
;
	typedef struct packed {
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] q;
		logic        err;
		logic        snk;
	} psw_row_type;

	logic             clk_in = 1'b0;
	logic             sys_rst_in = 1'b1;
	logic             por_in = 1'b0;
	logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0]      paddr = 12'h000;
	logic [31:0]      pwdata = 32'h00000000;
	logic             pready, pslverr, cpu_clk_en_out, sys_clk_en_out;
	logic [31:0]      prdata;
	psw_save_req_type save_req_in = '0;
	psw_wake_src_type wake_src_in = '0;
	logic [7:0]       periph_dis_in = 8'h00;
	logic [7:0]       periph_clk_out;
	logic             pin, charge_in = 1'b0;
	logic             low_power_rc_osc_en_out, wdt_clear_out, wake_pulse_out;
	logic             sink_en_out, irq_out, lo;
	int               bad_count = 0, tests_run = 0, n;
	psw_row_type      rows [8] = '{
		'{12'h768, 32'hFFFFFFFF, 32'h0000A100, 1'b0, 1'b1},
		'{12'h768, 32'h00008000, 32'h00008000, 1'b0, 1'b0},
		'{12'h768, 32'h00000100, 32'h00000100, 1'b0, 1'b0},
		'{12'h768, 32'h00002000, 32'h00002000, 1'b0, 1'b0},
		'{12'h770, 32'hFFFFFFFF, 32'h00000007, 1'b0, 1'b0},
		'{12'h774, 32'hFFFFFFFF, 32'h00000003, 1'b0, 1'b0},
		'{12'h76C, 32'hFFFFFFFF, 32'h00000000, 1'b0, 1'b0},
		'{12'h7FC, 32'h12345678, 32'h00000000, 1'b1, 1'b0}};

	////////////////////////////////////////////////////////////////////////
	// design and the rc network on its wake-up pin
	psw_top dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .por_in(por_in),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .save_req_in(save_req_in),
		.wake_src_in(wake_src_in), .periph_dis_in(periph_dis_in),
		.wakeup_pin_in(pin), .cpu_clk_en_out(cpu_clk_en_out),
		.sys_clk_en_out(sys_clk_en_out), .periph_clk_out(periph_clk_out),
		.low_power_rc_osc_en_out(low_power_rc_osc_en_out), .wdt_clear_out(wdt_clear_out),
		.wake_pulse_out(wake_pulse_out), .sink_en_out(sink_en_out),
		.irq_out(irq_out));
	psw_rc_model rc (.clk_in(clk_in), .charge_in(charge_in),
		.sink_in(sink_en_out), .pin_out(pin));

	// 250 MHz system clock
	initial
	begin
		forever #2 clk_in = ~clk_in;
	end

	////////////////////////////////////////////////////////////////////////
	// verdict, comparison and bus tasks
	task automatic finish_test;
		if (bad_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		tests_run++;
		if (s !== e)
		begin
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
			bad_count++;
		end
	endtask : chk

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk_in);
			k++;
		end
		while (pready !== 1'b1 && k < 8);
		r = prdata;
		e = pslverr;
		if (pready !== 1'b1)
		begin
			chk("pready timeout", 1, 0);
			finish_test();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_in);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] q,
		input logic err);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h00000000, r, e);
		chk("read data", q, r);
		chk("slverr", {31'h0, err}, {31'h0, e});
	endtask : rd

	// bounded wait on a design output; running out ends the run
	task automatic wait_for(ref logic s, input logic v, input int mx);
		int k;
		for (k = 0; k < mx && s !== v; k++)
			@(posedge clk_in);
		if (s !== v)
		begin
			chk("wait timeout", 1, 0);
			finish_test();
		end
	endtask : wait_for

	// power-save instruction: one-cycle valid, mode held afterwards
	task automatic sreq(input logic m);
		save_req_in <= '{1'b1, m};
		@(posedge clk_in);
		save_req_in.valid <= 1'b0;
	endtask : sreq

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		repeat (3) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_in);
		chk("reset outs", {3'b111, 4'h0, 8'hFF}, {cpu_clk_en_out,
			sys_clk_en_out, low_power_rc_osc_en_out, wdt_clear_out, wake_pulse_out,
			sink_en_out, irq_out, periph_clk_out});
		rd(12'h768, 32'h00000000, 1'b0);
		// register table, sink gating and the unmapped slot
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].q, rows[i].err);
			chk("sink", {31'h0, rows[i].snk}, {31'h0, sink_en_out});
		end
		// idle entry and wake by each of the three causes
		periph_dis_in <= 8'h0F;
		wr(12'h774, 32'h00000001);
		for (int k = 0; k < 3; k++)
		begin
			sreq(PSW_MODE_IDLE);
			wait_for(cpu_clk_en_out, 1'b0, 4);
			chk("idle outs", {3'b111, 8'hF0}, {wdt_clear_out,
				sys_clk_en_out, low_power_rc_osc_en_out, periph_clk_out});
			repeat (4) @(posedge clk_in);
			chk("halted", 0, {cpu_clk_en_out, wdt_clear_out});
			rd(12'h778, 32'h00000002, 1'b0);
			wake_src_in <= psw_wake_src_type'(3'h1 << k);
			wait_for(wake_pulse_out, 1'b1, 3);
			chk("resume", 1, cpu_clk_en_out);
			wake_src_in <= '0;
		end
		rd(12'h76C, 32'h00000002, 1'b0);
		// interrupt coinciding with the instruction
		save_req_in <= '{1'b1, PSW_MODE_IDLE};
		wake_src_in <= 3'h4;
		@(posedge clk_in);
		save_req_in.valid <= 1'b0;
		wake_src_in <= '0;
		lo = 1'b0;
		for (n = 0; n < 8 && wake_pulse_out !== 1'b1; n++)
		begin
			@(posedge clk_in);
			lo = lo | (cpu_clk_en_out === 1'b0);
		end
		chk("deferred irq", 3, {lo, wake_pulse_out});
		// power-on reset in mid idle
		wr(12'h768, 32'h0000A100);
		sreq(PSW_MODE_IDLE);
		wait_for(cpu_clk_en_out, 1'b0, 4);
		por_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		por_in <= 1'b0;
		@(posedge clk_in);
		chk("por outs", 3'b100, {cpu_clk_en_out, sink_en_out,
			wdt_clear_out});
		rd(12'h768, 32'h00000000, 1'b0);
		// charge, release, discharge, sleep, wake on the pin
		periph_dis_in <= 8'h00;
		charge_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		charge_in <= 1'b0;
		wr(12'h768, 32'h00008100);
		@(posedge clk_in);
		chk("sink on", 1, sink_en_out);
		sreq(PSW_MODE_SLEEP);
		wait_for(sys_clk_en_out, 1'b0, 4);
		chk("sleep outs", 0, {cpu_clk_en_out, low_power_rc_osc_en_out,
			periph_clk_out});
		wait_for(wake_pulse_out, 1'b1, 80);
		wr(12'h768, 32'h00000000);
		rd(12'h76C, 32'h00000005, 1'b0);
		wr(12'h76C, 32'h00000000);
		rd(12'h76C, 32'h00000005, 1'b0);
		chk("irq masked", 0, irq_out);
		wr(12'h770, 32'h00000001);
		@(posedge clk_in);
		chk("irq on", 1, irq_out);
		wr(12'h76C, 32'h00000001);
		@(posedge clk_in);
		chk("irq cleared", 0, irq_out);
		rd(12'h76C, 32'h00000004, 1'b0);
		finish_test();
	end
endmodule : psw_tb_top
